// file: core/ssr_pkg.sv
// Purpose: Shared constants and types for the security-register program and read block.
// Assumes: Single-bit serial link, three 256-byte one-time-lockable registers.
// Notes:   Opcodes, address field bounds, serial bit positions and program timing are named here.
//
// Contract
// - program accepted only with write enable latch set
// - one program writes one to 256 bytes
// - address bits 15:12 select register one to three
// - locked register ignores program commands permanently
// - opcode and address sampled on rising clock
// - read data MSB first on falling edges
// - byte address advances after each output byte
// - read address wraps within the same register
// - read runs until chip select rises
package ssr_pkg;

    // ---------------------------------------------------------------
    // Command codes and array geometry
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_PROG     = 8'h42;
    localparam logic [7:0] OP_READ     = 8'h48;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int         REG_BYTES   = 256;
    localparam int         NUM_REGS    = 3;

    // ---------------------------------------------------------------
    // Address field layout
    // ---------------------------------------------------------------
    localparam int         ADDR_TOP_HI = 23;
    localparam int         ADDR_TOP_LO = 16;
    localparam int         ADDR_SEL_HI = 15;
    localparam int         ADDR_SEL_LO = 12;
    localparam int         ADDR_MID_HI = 11;
    localparam int         ADDR_MID_LO = 8;
    localparam int         ADDR_BYTE_HI = 7;
    localparam logic [3:0] SEL_FIRST   = 4'h1;
    localparam logic [3:0] SEL_LAST    = 4'h3;

    // ---------------------------------------------------------------
    // Serial bit positions, counted in rising clock edges
    // ---------------------------------------------------------------
    localparam logic [5:0] BIT_ADDR_LAST  = 6'h1f;
    localparam logic [5:0] BIT_DATA_FIRST = 6'h20;
    localparam logic [5:0] BIT_DUMMY_END  = 6'h28;
    localparam logic [2:0] BIT_BYTE_LAST  = 3'h7;

    // ---------------------------------------------------------------
    // Timing of the self-timed program cycle
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PROG_TIME_US  = 400;
    localparam int PROG_CYC      = PROG_TIME_US * 1000000 / CLK_PERIOD_PS;

    // Core sequencer states.
    typedef enum logic [1:0] {
        CORE_IDLE,
        CORE_WAIT,
        CORE_COMMIT,
        CORE_DONE
    } ssr_core_st_t;

endpackage

// file: core/ssr_sync.sv
// Purpose: Two-flop level synchroniser for a small group of independent bits.
// Assumes: Each bit is a level or a toggle; no multi-bit word crosses here.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module ssr_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    import ssr_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ssr_sync_st_t;

    ssr_sync_st_t st_ff;
    ssr_sync_st_t nxt_st;

    if (W < 1) begin : g_chk
        $error("ssr_sync needs at least one bit.");
    end

    // Shifts the input through two stages.
    always_comb begin
        nxt_st.meta = i_async;
        nxt_st.sync = st_ff.meta;
    end

    // Registers the stages.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.sync;

endmodule

// file: core/ssr_otp_mem.sv
// Purpose: Storage for the three security registers with a bit-clearing write port.
// Assumes: Register select runs from one to NREG for every write and fetch; zero is presented only between reset and first use.
// Notes:   A write ANDs new data into the old byte, so bits only fall from one to zero.
`timescale 1ns/1ps
module ssr_otp_mem #(
    parameter int NREG  = 3,
    parameter int DEPTH = 256
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_wr_en,
    input  wire logic [1:0] i_wr_sel,
    input  wire logic [7:0] i_wr_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic [1:0] i_rd_sel,
    input  wire logic [7:0] i_rd_addr,
    output logic      [7:0] o_rd_data
);
    import ssr_pkg::*;

    localparam int IW = $clog2(NREG * DEPTH);

    logic [7:0]    mem [0:NREG*DEPTH-1];
    logic [IW-1:0] wr_idx;
    logic [IW-1:0] rd_idx;

    if (DEPTH != REG_BYTES || NREG < 1 || NREG > NUM_REGS) begin : g_chk
        $error("ssr_otp_mem geometry not supported.");
    end

    // Flattens select and byte position into one index.
    assign wr_idx = IW'((32'(i_wr_sel) - 32'h1) * DEPTH + 32'(i_wr_addr));
    assign rd_idx = IW'((32'(i_rd_sel) - 32'h1) * DEPTH + 32'(i_rd_addr));

    // Starts erased after reset and clears bits on each write.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < NREG * DEPTH; i++) begin
                mem[i] <= ERASED_BYTE;
            end
            o_rd_data <= ERASED_BYTE;
        end else begin
            if (i_wr_en) begin
                mem[wr_idx] <= mem[wr_idx] & i_wr_data;
            end
            o_rd_data <= mem[rd_idx];
        end
    end

endmodule

// file: core/ssr_top.sv
// Purpose: Security-register program and read command logic behind the serial pins.
// Assumes: The host keeps chip select low through a whole command and meets setup times.
// Notes:   Link logic runs on the serial clock; storage and the program timer run on
//          the reference clock. Words cross as toggles with data held stable.
`timescale 1ns/1ps
module ssr_top
    import ssr_pkg::*;
#(
    parameter int P_PROG_CYC = PROG_CYC
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_sclk,
    input  wire logic       i_cs_b,
    input  wire logic       i_serial_in,
    output logic            o_serial_out,
    output logic            o_serial_out_oe_b,
    input  wire logic       i_write_enable_latch,
    input  wire logic [3:0] i_otp_lock_bits,
    output logic            o_busy,
    output logic            o_latch_clear
);

    localparam int TW = $clog2(P_PROG_CYC + 1);

    if (P_PROG_CYC < 1) begin : g_chk
        $error("ssr_top needs a program time of at least one cycle.");
    end

    // ---------------------------------------------------------------
    // State types
    // ---------------------------------------------------------------

    // Frame state on the rising serial edge; cleared whenever chip select is high.
    typedef struct packed {
        logic [5:0]  cnt;
        logic [31:0] sr;
        logic [7:0]  op;
        logic        addr_ok;
        logic [1:0]  sel;
        logic [7:0]  wptr;
        logic [2:0]  bitn;
        logic [7:0]  dbyte;
    } ssr_frame_t;

    // Data handed to the core; survives chip select so the core can read it late.
    typedef struct packed {
        logic       wr_tgl;
        logic [7:0] wr_data;
        logic [7:0] wr_addr;
        logic [1:0] wr_sel;
    } ssr_hand_t;

    // Output shifter on the falling serial edge.
    typedef struct packed {
        logic [7:0] out;
        logic       drive;
        logic [2:0] ocnt;
        logic       rd_tgl;
        logic [1:0] rd_sel;
        logic [7:0] rd_addr;
    } ssr_shift_t;

    // Reference-clock sequencer state.
    typedef struct packed {
        ssr_core_st_t         st;
        logic [TW-1:0]        tmr;
        logic [7:0]           idx;
        logic                 cs_q;
        logic                 wr_q;
        logic                 rd_q;
        logic [1:0]           psel;
        logic                 got;
        logic [REG_BYTES-1:0] valid;
        logic [1:0]           rsel;
        logic [7:0]           raddr;
        logic                 lat_clr;
    } ssr_core_t;

    ssr_frame_t fr_ff;
    ssr_frame_t nxt_fr;
    ssr_hand_t  hd_ff;
    ssr_hand_t  nxt_hd;
    ssr_shift_t sh_ff;
    ssr_shift_t nxt_sh;
    ssr_core_t  co_ff;
    ssr_core_t  nxt_co;

    logic        frame_rst_b;
    logic [31:0] nsr;
    logic        hdr_ok;
    logic        rd_go;
    logic [2:0]  sync_q;
    logic        cs_s;
    logic        wr_ev;
    logic        rd_ev;
    logic        cs_rise;
    logic        buf_we;
    logic        mem_we;
    logic [7:0]  mem_rd_data;
    logic [7:0]  pbuf [0:REG_BYTES-1];

    // ---------------------------------------------------------------
    // Link side: input shifting on the rising serial edge
    // ---------------------------------------------------------------

    // A high chip select holds the frame state cleared, so each command starts fresh.
    assign frame_rst_b = i_rst_b & ~i_cs_b;

    // Next shift value and header check on the last address bit.
    assign nsr    = {fr_ff.sr[30:0], i_serial_in};
    assign hdr_ok = (nsr[ADDR_TOP_HI:ADDR_TOP_LO] == '0)
                  && (nsr[ADDR_MID_HI:ADDR_MID_LO] == '0)
                  && (nsr[ADDR_SEL_HI:ADDR_SEL_LO] >= SEL_FIRST)
                  && (nsr[ADDR_SEL_HI:ADDR_SEL_LO] <= SEL_LAST);

    // Counts bits, captures opcode and address, and packs program bytes.
    always_comb begin
        nxt_fr = fr_ff;
        nxt_hd = hd_ff;
        nxt_fr.sr = nsr;
        if (fr_ff.cnt != BIT_DUMMY_END) begin
            nxt_fr.cnt = fr_ff.cnt + 6'h01;
        end
        if (fr_ff.cnt == BIT_ADDR_LAST) begin
            nxt_fr.op      = nsr[31:24];
            nxt_fr.addr_ok = hdr_ok;
            nxt_fr.sel     = nsr[ADDR_SEL_LO+1:ADDR_SEL_LO];
            nxt_fr.wptr    = nsr[ADDR_BYTE_HI:0];
        end
        if (fr_ff.cnt >= BIT_DATA_FIRST) begin
            nxt_fr.dbyte = {fr_ff.dbyte[6:0], i_serial_in};
            nxt_fr.bitn  = fr_ff.bitn + 3'h1;
            // Only a whole eighth bit hands a byte over; a cut byte is dropped.
            if (fr_ff.bitn == BIT_BYTE_LAST && fr_ff.op == OP_PROG && fr_ff.addr_ok) begin
                nxt_hd.wr_tgl  = ~hd_ff.wr_tgl;
                nxt_hd.wr_data = {fr_ff.dbyte[6:0], i_serial_in};
                nxt_hd.wr_addr = fr_ff.wptr;
                nxt_hd.wr_sel  = fr_ff.sel;
                nxt_fr.wptr    = fr_ff.wptr + 8'h01;
            end
        end
    end

    // Registers the frame state.
    always_ff @(posedge i_sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            fr_ff <= '0;
        end else begin
            fr_ff <= nxt_fr;
        end
    end

    // Registers the hand-over word.
    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hd_ff <= '0;
        end else begin
            hd_ff <= nxt_hd;
        end
    end

    // ---------------------------------------------------------------
    // Link side: output shifting on the falling serial edge
    // ---------------------------------------------------------------

    assign rd_go = (fr_ff.op == OP_READ) && fr_ff.addr_ok;

    // Requests bytes from the core and shifts them out MSB first.
    always_comb begin
        nxt_sh = sh_ff;
        if (fr_ff.cnt < BIT_DATA_FIRST) begin
            nxt_sh.drive = 1'b0;
            nxt_sh.ocnt  = '0;
        end else if (fr_ff.cnt == BIT_DATA_FIRST) begin
            // First fetch goes out during the dummy clocks.
            if (rd_go) begin
                nxt_sh.rd_sel  = fr_ff.sel;
                nxt_sh.rd_addr = fr_ff.wptr;
                nxt_sh.rd_tgl  = ~sh_ff.rd_tgl;
            end
        end else if (fr_ff.cnt == BIT_DUMMY_END && rd_go) begin
            if (sh_ff.ocnt == '0) begin
                nxt_sh.out     = mem_rd_data;
                nxt_sh.drive   = 1'b1;
                nxt_sh.ocnt    = BIT_BYTE_LAST;
                nxt_sh.rd_addr = sh_ff.rd_addr + 8'h01;
                nxt_sh.rd_tgl  = ~sh_ff.rd_tgl;
            end else begin
                nxt_sh.out  = {sh_ff.out[6:0], 1'b0};
                nxt_sh.ocnt = sh_ff.ocnt - 3'h1;
            end
        end
    end

    // Registers the output shifter on the falling edge.
    always_ff @(negedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sh_ff <= '0;
        end else begin
            sh_ff <= nxt_sh;
        end
    end

    // The driver lets go at once when chip select rises or a new frame begins.
    assign o_serial_out      = sh_ff.out[7];
    assign o_serial_out_oe_b = ~sh_ff.drive | i_cs_b | (fr_ff.cnt != BIT_DUMMY_END);

    // ---------------------------------------------------------------
    // Crossing into the reference clock
    // ---------------------------------------------------------------

    // Chip select and both request toggles pass two flops.
    ssr_sync #(
        .W (3)
    ) u_sync (
        .i_clk   (i_ref_clk),
        .i_rst_b (i_rst_b),
        .i_async ({i_cs_b, hd_ff.wr_tgl, sh_ff.rd_tgl}),
        .o_sync  (sync_q)
    );

    assign cs_s    = sync_q[2];
    assign wr_ev   = sync_q[1] ^ co_ff.wr_q;
    assign rd_ev   = sync_q[0] ^ co_ff.rd_q;
    assign cs_rise = cs_s & ~co_ff.cs_q;
    assign buf_we  = wr_ev && (co_ff.st == CORE_IDLE);

    // ---------------------------------------------------------------
    // Core sequencer
    // ---------------------------------------------------------------

    // Gathers program bytes, runs the timed write and serves read fetches.
    always_comb begin
        nxt_co         = co_ff;
        nxt_co.cs_q    = cs_s;
        nxt_co.wr_q    = sync_q[1];
        nxt_co.rd_q    = sync_q[0];
        nxt_co.lat_clr = 1'b0;
        if (rd_ev) begin
            nxt_co.rsel  = sh_ff.rd_sel;
            nxt_co.raddr = sh_ff.rd_addr;
        end
        if (buf_we) begin
            nxt_co.valid[hd_ff.wr_addr] = 1'b1;
            nxt_co.psel = hd_ff.wr_sel;
            nxt_co.got  = 1'b1;
        end
        case (co_ff.st)
            CORE_IDLE: begin
                if (cs_rise && nxt_co.got) begin
                    if (i_write_enable_latch && !i_otp_lock_bits[nxt_co.psel]) begin
                        nxt_co.st  = CORE_WAIT;
                        nxt_co.tmr = TW'(P_PROG_CYC - 1);
                    end else begin
                        nxt_co.got   = 1'b0;
                        nxt_co.valid = '0;
                    end
                end
            end
            CORE_WAIT: begin
                if (co_ff.tmr == '0) begin
                    nxt_co.st  = CORE_COMMIT;
                    nxt_co.idx = '0;
                end else begin
                    nxt_co.tmr = co_ff.tmr - TW'(1);
                end
            end
            CORE_COMMIT: begin
                nxt_co.idx = co_ff.idx + 8'h01;
                if (co_ff.idx == 8'(REG_BYTES - 1)) begin
                    nxt_co.st = CORE_DONE;
                end
            end
            CORE_DONE: begin
                nxt_co.lat_clr = 1'b1;
                nxt_co.valid   = '0;
                nxt_co.got     = 1'b0;
                nxt_co.st      = CORE_IDLE;
            end
            default: begin
                nxt_co.st = CORE_IDLE;
            end
        endcase
    end

    // Registers the core state.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            co_ff    <= '0;
            co_ff.st <= CORE_IDLE;
        end else begin
            co_ff <= nxt_co;
        end
    end

    // Staging bytes; only entries marked valid are ever committed.
    always_ff @(posedge i_ref_clk) begin
        if (buf_we) begin
            pbuf[hd_ff.wr_addr] <= hd_ff.wr_data;
        end
    end

    assign mem_we = (co_ff.st == CORE_COMMIT) && co_ff.valid[co_ff.idx];

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------

    // Commit writes and read fetches share the array.
    ssr_otp_mem #(
        .NREG  (NUM_REGS),
        .DEPTH (REG_BYTES)
    ) u_mem (
        .i_clk     (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_wr_en   (mem_we),
        .i_wr_sel  (co_ff.psel),
        .i_wr_addr (co_ff.idx),
        .i_wr_data (pbuf[co_ff.idx]),
        .i_rd_sel  (co_ff.rsel),
        .i_rd_addr (co_ff.raddr),
        .o_rd_data (mem_rd_data)
    );

    // Status toward the rest of the flash.
    assign o_busy        = (co_ff.st != CORE_IDLE);
    assign o_latch_clear = co_ff.lat_clr;

endmodule

// file: dv/ssr_checker.sv
// Purpose: Port assertions for the security-register block.
// Assumes: Serial clock and reference clock are unrelated in phase.
// Notes:   Bound to every ssr_top instance below.
`timescale 1ns/1ps
module ssr_checker #(
    parameter int P_PROG_CYC = 20
) (
    input wire logic       i_ref_clk,
    input wire logic       i_rst_b,
    input wire logic       i_sclk,
    input wire logic       i_cs_b,
    input wire logic       i_serial_in,
    input wire logic       o_serial_out,
    input wire logic       o_serial_out_oe_b,
    input wire logic       i_write_enable_latch,
    input wire logic [3:0] i_otp_lock_bits,
    input wire logic       o_busy,
    input wire logic       o_latch_clear
);
    logic [5:0]  rise_cnt_ff;
    logic [31:0] busy_cnt_ff;

    // Count serial rising edges in a frame; chip select high clears it.
    always_ff @(posedge i_sclk or posedge i_cs_b) begin
        if (i_cs_b) rise_cnt_ff <= 6'h00;
        else if (rise_cnt_ff != 6'h3f) rise_cnt_ff <= rise_cnt_ff + 6'h01;
    end

    // Count reference cycles while busy is high.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) busy_cnt_ff <= 32'h0;
        else if (o_busy) busy_cnt_ff <= busy_cnt_ff + 32'h1;
        else busy_cnt_ff <= 32'h0;
    end

    a_oe_cs_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        i_cs_b |-> o_serial_out_oe_b) else $error("output enabled while deselected");
    a_out_on_fall: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        $changed(o_serial_out) |-> !i_sclk) else $error("data out changed with clock high");
    a_oe_on_fall: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        $fell(o_serial_out_oe_b) |-> !i_sclk && !i_cs_b) else $error("output enable off edge");
    a_oe_after_dummy: assert property (@(posedge i_sclk) disable iff (i_cs_b || !i_rst_b)
        !o_serial_out_oe_b |-> rise_cnt_ff >= 6'h28) else $error("data before dummy clocks end");
    a_busy_after_cs: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        $rose(o_busy) |-> i_cs_b && $past(i_cs_b, 3)) else $error("busy rose inside a frame");
    a_busy_needs_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        $rose(o_busy) |-> i_write_enable_latch) else $error("program without write enable");
    a_busy_length: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        $fell(o_busy) |-> busy_cnt_ff >= P_PROG_CYC + 256 && busy_cnt_ff <= P_PROG_CYC + 260)
        else $error("busy length wrong");
    a_latch_clr_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        o_latch_clear |=> !o_latch_clear) else $error("latch clear longer than one cycle");
    a_latch_clr_end: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        $fell(o_busy) |-> ((o_latch_clear || $past(o_latch_clear)) or (##1 o_latch_clear)))
        else $error("no latch clear at end of program");
endmodule

bind ssr_top ssr_checker #(.P_PROG_CYC(P_PROG_CYC)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_cs_b(i_cs_b),
    .i_serial_in(i_serial_in), .o_serial_out(o_serial_out), .o_serial_out_oe_b(o_serial_out_oe_b),
    .i_write_enable_latch(i_write_enable_latch), .i_otp_lock_bits(i_otp_lock_bits),
    .o_busy(o_busy), .o_latch_clear(o_latch_clear)
);

// file: dv/ssr_host_model.sv
// Purpose: Serial host that frames program and read commands.
// Assumes: Serial clock period 48 ns, idle low between frames.
// Notes:   Unused data input toggles so stale values never look valid.
`timescale 1ns/1ps
module ssr_host_model (
    output logic o_sclk,
    output logic o_cs_b,
    output logic o_serial_in
);
    localparam realtime HALF = 24.0;

    // Idle the link: deselected, clock stopped.
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_serial_in = 1'b0;
    end

    // One serial bit: data set while low, taken on the rising edge.
    task automatic shift(input logic b);
        o_serial_in = b;
        #(HALF);
        o_sclk = 1'b1;
        #(HALF);
        o_sclk = 1'b0;
    endtask

    // Whole frame: header, data bytes, or dummy plus read clocks.
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nwr,
                         input logic [7:0] d [0:3], input int nrd);
        logic [31:0] hdr;
        hdr = {op, a};
        #(1.3);
        o_cs_b = 1'b0;
        for (int i = 31; i >= 0; i--) shift(hdr[i]);
        for (int i = 0; i < nwr * 8; i++) shift(d[i / 8][7 - i % 8]);
        for (int i = 0; i < (nrd > 0 ? 8 + nrd * 8 : 0); i++) shift(~o_serial_in);
        #(HALF);
        o_cs_b = 1'b1;
        o_serial_in = ~o_serial_in;
        #(100);
    endtask
endmodule

// file: dv/test_security_register_program_read.sv
// Purpose: Self-checking bench for program and read of the security registers.
// Assumes: Short program time parameter; bench models the status latch.
// Notes:   A mirror of the storage predicts every byte read back.
`timescale 1ns/1ps
module test_security_register_program_read;
    import ssr_pkg::*;
    logic       i_ref_clk, i_rst_b, sclk, cs_b, sin, wr_latch;
    logic       o_serial_out, o_serial_out_oe_b, o_busy, o_latch_clear;
    logic [3:0] lock;
    logic [7:0] exp_q[$];
    logic [7:0] d [0:3];
    logic [7:0] mem [0:3][0:255];
    logic [7:0] sh;
    logic [23:0] bad [0:3] = '{24'h004000, 24'h000000, 24'h011000, 24'h001100};
    int         nb, rx_cnt, clr_cnt, fails, checks, seed;

    ssr_host_model u_host (.o_sclk(sclk), .o_cs_b(cs_b), .o_serial_in(sin));
    ssr_top #(.P_PROG_CYC(20)) DUT (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_cs_b(cs_b), .i_serial_in(sin),
        .o_serial_out(o_serial_out), .o_serial_out_oe_b(o_serial_out_oe_b),
        .i_write_enable_latch(wr_latch), .i_otp_lock_bits(lock), .o_busy(o_busy), .o_latch_clear(o_latch_clear)
    );

    // -----------------------------------------------------------
    // Checking and closing
    // -----------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reference clock, 5 ns period.
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    // Assemble read bytes and compare with the oldest expected one.
    always @(posedge sclk) begin
        if (o_serial_out_oe_b === 1'b0) begin
            sh = {sh[6:0], o_serial_out};
            nb++;
            if (nb == 8) begin
                nb = 0;
                rx_cnt++;
                check({24'h0, sh}, exp_q.size() > 0 ? {24'h0, exp_q.pop_front()} : 32'hdead);
            end
        end
    end

    // Chip select rising restarts byte assembly; count latch clear pulses.
    always @(posedge cs_b) nb = 0;
    always @(negedge i_ref_clk) if (o_latch_clear === 1'b1) clr_cnt++;

    // Program through the host; predict busy, latch clear and storage.
    task automatic prog(input logic [23:0] a, input int n, input logic en, input logic [3:0] lk,
                        input logic acc);
        int k;
        int t;
        @(negedge i_ref_clk);
        wr_latch = en;
        lock = lk;
        k = clr_cnt;
        for (int i = 0; i < 4; i++) d[i] = 8'($random(seed));
        u_host.frame(OP_PROG, a, n, d, 0);
        repeat (8) @(negedge i_ref_clk);
        check(o_busy, acc);
        for (t = 0; t < 1000 && o_busy !== 1'b0; t++) @(negedge i_ref_clk);
        // One more edge so the clear-pulse counter has surely counted the last pulse.
        @(negedge i_ref_clk);
        check(clr_cnt - k, acc);
        wr_latch = 1'b0;
        if (acc) for (int i = 0; i < n; i++) mem[a[13:12]][a[7:0] + 8'(i)] &= d[i];
    endtask

    // Read n bytes; invalid addresses must never enable the output.
    task automatic rd(input logic [23:0] a, input int n, input logic ok);
        logic [7:0] p;
        int r0;
        p = a[7:0];
        r0 = rx_cnt;
        for (int i = 0; i < n; i++) begin
            if (ok) exp_q.push_back(mem[a[13:12]][p]);
            p = p + 8'h01;
        end
        u_host.frame(OP_READ, a, 0, d, n);
        check(rx_cnt - r0, ok ? n : 0);
        check(exp_q.size(), 0);
    endtask

    // Watchdog against a hung handshake.
    initial begin
        #(400000);
        fails++;
        $display("watchdog expired");
        complete_run();
    end

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        i_rst_b = 1'b0;
        wr_latch = 1'b0;
        lock = 4'h0;
        seed = 82;
        foreach (mem[r, b]) mem[r][b] = ERASED_BYTE;
        repeat (6) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        rd(24'h0010fe, 3, 1'b1);
        $display("erased read with wrap done");
        prog(24'h0020fe, 3, 1'b1, 4'h0, 1'b1);
        rd(24'h0020fd, 5, 1'b1);
        $display("program across wrap done");
        prog(24'h003010, 1, 1'b0, 4'h0, 1'b0);
        rd(24'h003010, 1, 1'b1);
        $display("program without latch done");
        prog(24'h001020, 2, 1'b1, 4'h2, 1'b0);
        prog(24'h003000, 1, 1'b1, 4'h2, 1'b1);
        rd(24'h001020, 2, 1'b1);
        rd(24'h003000, 1, 1'b1);
        $display("locked register done");
        for (int i = 0; i < 4; i++) begin
            prog(bad[i], 1, 1'b1, 4'h0, 1'b0);
            rd(bad[i], 2, 1'b0);
        end
        $display("invalid addresses done");
        for (int r = 1; r <= 3; r++) rd({8'h00, 4'(r), 4'h0, 8'($random(seed))}, 2, 1'b1);
        $display("random reads done");
        complete_run();
    end
endmodule
